// ===== design/tmrx_pkg.sv
// package: register map, field positions and types for the timer/external interrupt block
package tmrx_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] TMRX_OFF_TCTRL = 8'h00;
  localparam logic [7:0] TMRX_OFF_EXTCTRL = 8'h04;
  localparam logic [7:0] TMRX_OFF_TFLAGS = 8'h08;
  localparam logic [7:0] TMRX_OFF_IRQSTAT = 8'h0C;
  localparam logic [7:0] TMRX_OFF_IRQMASK = 8'h10;
  localparam logic [7:0] TMRX_OFF_STATE = 8'h14;
  // tctrl fields
  localparam int TMRX_TC_RUN = 0;
  localparam int TMRX_TC_EXEN = 1;
  localparam int TMRX_TC_NODE_EN = 2;
  // extctrl fields (per channel: bypass, falling edge)
  localparam int TMRX_EC_BYP0 = 0;
  localparam int TMRX_EC_FALL0 = 1;
  localparam int TMRX_EC_BYP1 = 2;
  localparam int TMRX_EC_FALL1 = 3;
  // tflags fields (write 1 clears, also software set of ovf and ext only, via bits 8 and 9)
  localparam int TMRX_TF_OVF = 0;
  localparam int TMRX_TF_EXT = 1;
  localparam int TMRX_TF_XREQ0 = 2;
  localparam int TMRX_TF_XREQ1 = 3;
  localparam int TMRX_TF_XFLG0 = 4;
  localparam int TMRX_TF_XFLG1 = 5;
  localparam int TMRX_TF_SET_SHIFT = 8;
  // irq status fields
  localparam int TMRX_IS_TMR = 0;
  localparam int TMRX_IS_X0 = 1;
  localparam int TMRX_IS_X1 = 2;
  localparam int TMRX_IRQ_W = 3;
  // reset values
  localparam logic [2:0] TMRX_TCTRL_RST = 3'h0;
  localparam logic [3:0] TMRX_EXTCTRL_RST = 4'h0;
  localparam logic [TMRX_IRQ_W-1:0] TMRX_MASK_RST = 3'h0;
  localparam logic [31:0] TMRX_RD_UNMAPPED = 32'h0;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tmrx_apb_req_s;

  // events of one external interrupt channel
  typedef struct packed {
    logic edge_seen;
    logic pin_q;
  } tmrx_ext_s;
endpackage

// ===== design/tmrx_edge_det.sv
// rising edge detector for a request line, sampled every clock
`timescale 1ns/1ps
`default_nettype none
module tmrx_edge_det (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // request line in, edge pulse out
  input wire logic line,
  output logic rise
);
  logic prev_q;
  logic prev_d;

  // previous sample, compared with current one
  always_comb begin
    prev_d = line;
    rise = line & ~prev_q;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule
`default_nettype wire

// ===== design/tmrx_top.sv
// timer/external interrupt request detection block with apb registers
`timescale 1ns/1ps
`default_nettype none
module tmrx_top
  import tmrx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer events (same clock domain)
  input wire logic timer_overflow_event,
  input wire logic timer_external_event,
  // external interrupt pins (asynchronous)
  input wire logic ext_pin_zero,
  input wire logic ext_pin_one,
  // core interface
  input wire logic vector_ext_zero,
  input wire logic vector_ext_one,
  output logic timer_node_request,
  output logic ext_zero_request,
  output logic ext_one_request,
  output logic irq
);
  tmrx_apb_req_s req;
  logic wr_en;
  logic rd_en;

  // control registers
  logic [2:0] tctrl_q, tctrl_d;
  logic [3:0] extctrl_q, extctrl_d;
  logic [TMRX_IRQ_W-1:0] mask_q, mask_d;
  // flags
  logic timer_overflow_flag_q, timer_overflow_flag_d;
  logic timer_external_event_flag_q, timer_external_event_flag_d;
  logic [1:0] xreq_q, xreq_d; // request flags in timer control register
  logic [1:0] xflg_q, xflg_d; // flags in interrupt request control zero
  logic [TMRX_IRQ_W-1:0] stat_q, stat_d;
  // outputs
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic tnode_q, tnode_d;
  logic [1:0] xout_q, xout_d;
  logic irq_q, irq_d;
  // pins and edges
  logic [1:0] sync1_q, sync2_q, pin_prev_q;
  logic [1:0] fall_flag_prev_q;
  logic merged_line;
  logic timer_rise;
  logic [1:0] fall_edge;
  logic [1:0] rise_edge;
  logic [1:0] ext_event;
  logic [1:0] xflg_clr;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  // slave always answers in the access cycle, no wait states
  assign wr_en = req.psel & req.penable & req.pwrite;
  assign rd_en = req.psel & req.penable & ~req.pwrite;

  // merged request line leaving the timer kernel
  assign merged_line = timer_overflow_flag_q | timer_external_event_flag_q;

  // level on merged line is ignored; only its rise counts
  tmrx_edge_det u_edge (
    .clk(clk),
    .reset_n(reset_n),
    .line(merged_line),
    .rise(timer_rise)
  );

  // two-stage synchronisers, then edge detection off the second stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      pin_prev_q <= 2'h0; // same as sync stage, so no false edge after reset
      fall_flag_prev_q <= 2'h0;
    end else begin
      sync1_q <= {ext_pin_one, ext_pin_zero};
      sync2_q <= sync1_q;
      pin_prev_q <= sync2_q;
      fall_flag_prev_q <= xflg_q;
    end
  end

  // per channel event: normal edge, or bypass quirk on flag clear
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ext
      logic byp;
      logic fall_mode;
      assign byp = extctrl_q[2*g];
      assign fall_mode = extctrl_q[2*g+1];
      assign fall_edge[g] = pin_prev_q[g] & ~sync2_q[g];
      assign rise_edge[g] = ~pin_prev_q[g] & sync2_q[g];
      assign xflg_clr[g] = wr_en && req.paddr == TMRX_OFF_TFLAGS
                           && req.pwdata[TMRX_TF_XFLG0+g];
      // bypass detector sees a falling edge again after its flag drops
      assign ext_event[g] = (fall_mode ? fall_edge[g] : rise_edge[g])
                            | (byp & fall_mode & fall_flag_prev_q[g] & ~xflg_q[g]
                               & ~sync2_q[g]);
    end
  endgenerate

  // flags, control, status
  always_comb begin
    tctrl_d = tctrl_q;
    extctrl_d = extctrl_q;
    mask_d = mask_q;
    timer_overflow_flag_d = timer_overflow_flag_q;
    timer_external_event_flag_d = timer_external_event_flag_q;
    xreq_d = xreq_q;
    xflg_d = xflg_q;
    stat_d = stat_q;
    if (wr_en) begin
      case (req.paddr)
        TMRX_OFF_TCTRL: tctrl_d = req.pwdata[2:0];
        TMRX_OFF_EXTCTRL: extctrl_d = req.pwdata[3:0];
        TMRX_OFF_IRQMASK: mask_d = req.pwdata[TMRX_IRQ_W-1:0];
        TMRX_OFF_TFLAGS: begin
          if (req.pwdata[TMRX_TF_OVF]) timer_overflow_flag_d = 1'b0;
          if (req.pwdata[TMRX_TF_EXT]) timer_external_event_flag_d = 1'b0;
          if (req.pwdata[TMRX_TF_XREQ0]) xreq_d[0] = 1'b0;
          if (req.pwdata[TMRX_TF_XREQ1]) xreq_d[1] = 1'b0;
          xflg_d = xflg_q & ~xflg_clr;
          if (req.pwdata[TMRX_TF_SET_SHIFT + TMRX_TF_OVF]) timer_overflow_flag_d = 1'b1;
          if (req.pwdata[TMRX_TF_SET_SHIFT + TMRX_TF_EXT]) timer_external_event_flag_d = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // read of status clears it; hardware sets below still win
    if (rd_en && req.paddr == TMRX_OFF_IRQSTAT) begin
      stat_d = '0;
    end
    // vectoring clears the request flag
    if (vector_ext_zero) xreq_d[0] = 1'b0;
    if (vector_ext_one) xreq_d[1] = 1'b0;
    // hardware sets win over software clears
    if (tctrl_q[TMRX_TC_RUN] && timer_overflow_event) begin
      timer_overflow_flag_d = 1'b1;
    end
    if (tctrl_q[TMRX_TC_RUN] && tctrl_q[TMRX_TC_EXEN] && timer_external_event) begin
      timer_external_event_flag_d = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (ext_event[i]) begin
        xreq_d[i] = 1'b1;
        xflg_d[i] = 1'b1;
      end
    end
    // a stuck timer line only hides the timer's own edge
    if (timer_rise) stat_d[TMRX_IS_TMR] = 1'b1;
    if (ext_event[0]) stat_d[TMRX_IS_X0] = 1'b1;
    if (ext_event[1]) stat_d[TMRX_IS_X1] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tctrl_q <= TMRX_TCTRL_RST;
      extctrl_q <= TMRX_EXTCTRL_RST;
      mask_q <= TMRX_MASK_RST;
      timer_overflow_flag_q <= 1'b0;
      timer_external_event_flag_q <= 1'b0;
      xreq_q <= 2'h0;
      xflg_q <= 2'h0;
      stat_q <= '0;
    end else begin
      tctrl_q <= tctrl_d;
      extctrl_q <= extctrl_d;
      mask_q <= mask_d;
      timer_overflow_flag_q <= timer_overflow_flag_d;
      timer_external_event_flag_q <= timer_external_event_flag_d;
      xreq_q <= xreq_d;
      xflg_q <= xflg_d;
      stat_q <= stat_d;
    end
  end

  // bus answer and registered outputs
  always_comb begin
    pready_d = psel & ~penable;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (psel && !penable) begin
      prdata_d = TMRX_RD_UNMAPPED;
      case (paddr)
        TMRX_OFF_TCTRL: prdata_d = {29'h0, tctrl_q};
        TMRX_OFF_EXTCTRL: prdata_d = {28'h0, extctrl_q};
        TMRX_OFF_TFLAGS: prdata_d = {26'h0, xflg_q, xreq_q,
                                     timer_external_event_flag_q, timer_overflow_flag_q};
        TMRX_OFF_IRQSTAT: prdata_d = {29'h0, stat_q};
        TMRX_OFF_IRQMASK: prdata_d = {29'h0, mask_q};
        TMRX_OFF_STATE: prdata_d = {29'h0, merged_line, sync2_q[1], sync2_q[0]};
        default: pslverr_d = 1'b1;
      endcase
    end
    // one-cycle pulse to core on timer rise, gated by node enable
    tnode_d = timer_rise & tctrl_q[TMRX_TC_NODE_EN];
    xout_d = xreq_d;
    irq_d = |(stat_d & mask_q);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      tnode_q <= 1'b0;
      xout_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      tnode_q <= tnode_d;
      xout_q <= xout_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timer_node_request = tnode_q;
  assign ext_zero_request = xout_q[0];
  assign ext_one_request = xout_q[1];
  assign irq = irq_q;
endmodule
`default_nettype wire

// ===== verif/tmrx_top_properties.sv
// checker: timer request edge and apb answer properties
`timescale 1ns/1ps
`default_nettype none
module tmrx_top_chk import tmrx_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // timer events and core side
  input wire logic timer_overflow_event,
  input wire logic timer_external_event,
  input wire logic vector_ext_zero,
  input wire logic vector_ext_one,
  input wire logic timer_node_request,
  input wire logic ext_zero_request,
  input wire logic ext_one_request
);
  logic tf_wr;
  logic arm_q, arm_d;
  logic [3:0] ev_q, ev_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a flag register write is the only way the merged line can fall
  assign tf_wr = psel && penable && pwrite && paddr == TMRX_OFF_TFLAGS;
  // recent causes of a rise; armed after a pulse until flags may clear
  always_comb begin
    ev_d = {ev_q[2:0], timer_overflow_event | timer_external_event | tf_wr};
    arm_d = (arm_q | timer_node_request) & ~tf_wr;
  end
  always_ff @(posedge clk) begin
    ev_q <= reset_n ? ev_d : 4'h0;
    arm_q <= reset_n & arm_d;
  end
  chk_node_pulse: assert property (timer_node_request |=> !timer_node_request)
    else $error("timer request longer than one cycle");
  chk_no_retrigger: assert property (!(arm_q && timer_node_request))
    else $error("timer request again before flags cleared");
  chk_node_cause: assert property (timer_node_request |-> |ev_q)
    else $error("timer request without a recent cause");
  chk_vector_zero: assert property (vector_ext_zero |=> ##[0:2] !ext_zero_request)
    else $error("ext zero request kept after vectoring");
  chk_vector_one: assert property (vector_ext_one |=> ##[0:2] !ext_one_request)
    else $error("ext one request kept after vectoring");
  chk_setup_ack: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  chk_ack_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  chk_err_ack: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property (timer_node_request);
  cover property (vector_ext_zero);
  cover property (pslverr);
  cover property (ext_zero_request);
endmodule
bind tmrx_top tmrx_top_chk u_chk (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pready,
  .pslverr, .timer_overflow_event, .timer_external_event, .vector_ext_zero, .vector_ext_one,
  .timer_node_request, .ext_zero_request, .ext_one_request);
`default_nettype wire

// ===== verif/tmrx_core_model.sv
// core model: vectors once to each newly raised external request
`timescale 1ns/1ps
`default_nettype none
module tmrx_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // requests in, vectoring pulses out
  input wire logic vec_en,
  input wire logic ext_zero_request,
  input wire logic ext_one_request,
  output logic vector_ext_zero,
  output logic vector_ext_one
);
  logic [1:0] req_q, vec_q, vec_d;
  // software never clears the request itself; the block must do it
  always_comb vec_d = {2{vec_en}} & {ext_one_request, ext_zero_request} & ~req_q;
  always_ff @(posedge clk) begin
    req_q <= reset_n ? {ext_one_request, ext_zero_request} : 2'h0;
    vec_q <= reset_n ? vec_d : 2'h0;
  end
  assign {vector_ext_one, vector_ext_zero} = vec_q;
endmodule
`default_nettype wire

// ===== verif/tb_timer_extint_request_detect.sv
// testbench: timer and external interrupt request detection
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_timer_extint_request_detect import tmrx_pkg::*; ;
  logic clk = '0, reset_n = '0, psel = '0, penable = '0, pwrite = '0, vec_en = '0;
  logic timer_overflow_event = '0, timer_external_event = '0;
  logic ext_pin_zero = '0, ext_pin_one = '0, pready, pslverr, irq;
  logic vector_ext_zero, vector_ext_one, timer_node_request, ext_zero_request, ext_one_request;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h6F9625FA;
  logic [32:0] note;
  logic [32:0] expq[$];
  int n_errors = 0, checks_done = 0, n_pulse = 0, n_vec = 0;
  tmrx_top DUT (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .timer_overflow_event, .timer_external_event, .ext_pin_zero, .ext_pin_one,
    .vector_ext_zero, .vector_ext_one, .timer_node_request, .ext_zero_request,
    .ext_one_request, .irq);
  tmrx_core_model core (.clk, .reset_n, .vec_en, .ext_zero_request, .ext_one_request,
    .vector_ext_zero, .vector_ext_one);
  // clock, 40 ns period
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    expq.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask
  // one-cycle timer event, overflow or external
  task automatic ev(logic ovf);
    @(posedge clk);
    {timer_overflow_event, timer_external_event} <= {ovf, ~ovf};
    @(posedge clk);
    {timer_overflow_event, timer_external_event} <= 2'h0;
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // monitor: pulse counts at mid-cycle, where outputs are settled
  always @(negedge clk) begin
    if (timer_node_request === 1'b1) n_pulse++;
    if ((vector_ext_zero | vector_ext_one) === 1'b1) n_vec++;
  end
  // scoreboard: answer taken at the edge where pready is sampled high
  always @(posedge clk) begin
    if ((psel && penable && pready) === 1'b1) begin
      note = expq.pop_front();
      `CHK({pslverr, pwrite ? 32'h0 : prdata}, note)
    end
  end
  // watchdog, run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    seed = xs(seed);
    xfer(1'b0, TMRX_OFF_IRQMASK, 32'h0, 33'h0);
    xfer(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
    xfer(1'b1, TMRX_OFF_IRQMASK, seed, 33'h0);
    xfer(1'b0, TMRX_OFF_IRQMASK, 32'h0, {30'h0, seed[2:0]});
    xfer(1'b1, TMRX_OFF_TCTRL, 32'h5, 33'h0);
    ev(1'b0);
    xfer(1'b0, TMRX_OFF_TFLAGS, 32'h0, 33'h0);
    ev(1'b1);
    xfer(1'b0, TMRX_OFF_STATE, 32'h0, 33'h4);
    `CHK(n_pulse, 1)
    xfer(1'b1, TMRX_OFF_TCTRL, 32'h7, 33'h0);
    ev(1'b0);
    xfer(1'b1, TMRX_OFF_TFLAGS, 32'h1, 33'h0);
    ev(1'b1);
    xfer(1'b0, TMRX_OFF_TFLAGS, 32'h0, 33'h3);
    `CHK(n_pulse, 1)
    xfer(1'b1, TMRX_OFF_TFLAGS, 32'h3, 33'h0);
    // service routine rechecks both flags before it leaves
    xfer(1'b0, TMRX_OFF_TFLAGS, 32'h0, 33'h0);
    ev(1'b0);
    settle(3);
    `CHK(n_pulse, 2)
    xfer(1'b1, TMRX_OFF_IRQMASK, 32'h0, 33'h0);
    settle(2);
    `CHK(irq, 1'b0)
    xfer(1'b1, TMRX_OFF_IRQMASK, 32'h1, 33'h0);
    settle(2);
    `CHK(irq, 1'b1)
    xfer(1'b0, TMRX_OFF_IRQSTAT, 32'h0, 33'h1);
    xfer(1'b0, TMRX_OFF_IRQSTAT, 32'h0, 33'h0);
    settle(2);
    `CHK(irq, 1'b0)
    // pin one rises while the timer line stays high
    @(posedge clk) {vec_en, ext_pin_one} <= 2'h3;
    settle(12);
    xfer(1'b0, TMRX_OFF_TFLAGS, 32'h0, 33'h22);
    `CHK(n_vec, 1)
    `CHK(ext_one_request, 1'b0)
    // pin zero in bypass mode, falling edge active
    xfer(1'b1, TMRX_OFF_EXTCTRL, 32'h3, 33'h0);
    @(posedge clk) ext_pin_zero <= 1'b1;
    settle(8);
    @(posedge clk) ext_pin_zero <= 1'b0;
    settle(12);
    xfer(1'b0, TMRX_OFF_TFLAGS, 32'h0, 33'h32);
    xfer(1'b1, TMRX_OFF_TFLAGS, 32'h10, 33'h0);
    settle(12);
    xfer(1'b0, TMRX_OFF_TFLAGS, 32'h0, 33'h32);
    `CHK(n_vec, 3)
    `CHK(ext_zero_request, 1'b0)
    // node disabled: software polls the flags, no pulse reaches the core
    xfer(1'b1, TMRX_OFF_TCTRL, 32'h3, 33'h0);
    xfer(1'b1, TMRX_OFF_TFLAGS, 32'h3, 33'h0);
    ev(1'b1);
    xfer(1'b0, TMRX_OFF_TFLAGS, 32'h0, 33'h31);
    `CHK(n_pulse, 2)
    // software set of the overflow flag raises the merged line again
    xfer(1'b1, TMRX_OFF_TFLAGS, 32'h1, 33'h0);
    xfer(1'b1, TMRX_OFF_TCTRL, 32'h5, 33'h0);
    xfer(1'b1, TMRX_OFF_TFLAGS, 32'h100, 33'h0);
    settle(3);
    `CHK(n_pulse, 3)
    // write to an unmapped word is refused
    xfer(1'b1, 8'h18, seed, {1'b1, 32'h0});
    stop_test();
  end
endmodule
`default_nettype wire
